// ---- hw/cbm_pkg.sv ----
// Constants and types for the charger boost mode control block
package cbm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_HZ = 20000000;
    localparam int unsigned BOOST_TIMER_S = 32;
    localparam int unsigned CRUDE_TIMER_S = 32;
    localparam int unsigned OVERLOAD_MS = 30;
    localparam int unsigned FAULT_PULSE_US = 128;
    localparam int unsigned SOFT_START_US = 1000;
    localparam int unsigned BOOST_TIMER_CYCLES = BOOST_TIMER_S * CLOCK_HZ;
    localparam int unsigned CRUDE_TIMER_CYCLES = CRUDE_TIMER_S * CLOCK_HZ;
    localparam int unsigned OVERLOAD_CYCLES = OVERLOAD_MS * (CLOCK_HZ / 1000);
    localparam int unsigned FAULT_PULSE_CYCLES = FAULT_PULSE_US * (CLOCK_HZ / 1000000);
    localparam int unsigned SOFT_START_CYCLES = SOFT_START_US * (CLOCK_HZ / 1000000);
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_OPERATION_SELECT = 1'h0;
    localparam logic RST_HIZ_REQUEST = 1'h0;
    localparam logic RST_MODE_32MIN = 1'h0;
    // ------------------------------------------------------------
    // Fault field positions
    // ------------------------------------------------------------
    localparam int unsigned FLT_W = 5;
    localparam int unsigned FLT_TIMER = 0;
    localparam int unsigned FLT_BUS_OV = 1;
    localparam int unsigned FLT_OVERLOAD = 2;
    localparam int unsigned FLT_BAT_RANGE = 3;
    localparam int unsigned FLT_CHARGE = 4;
    // ------------------------------------------------------------
    // Operation modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CBM_HIZ = 2'h0,
        CBM_CHARGE = 2'h1,
        CBM_BOOST = 2'h3,
        CBM_CONFIG = 2'h2
    } cbm_mode_t;
endpackage : cbm_pkg

// ---- hw/cbm_timer.sv ----
// Load-and-count-down timer with expiry pulse
`timescale 1ns/1ps
module cbm_timer #(
    parameter int unsigned WIDTH = 30
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_expired
);
    initial begin
        if (WIDTH < 2) begin
            $error("cbm_timer width too small");
        end
    end
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic expired_q;
    logic expired_d;
    always_comb begin
        count_d = count_q;
        expired_d = 1'b0;
        if (i_load || !i_run) begin
            count_d = i_count;
        end else if (count_q == '0) begin
            count_d = i_count;
            expired_d = 1'b1;
        end else begin
            count_d = count_q - 1'b1;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            count_q <= '0;
            expired_q <= 1'b0;
        end else begin
            count_q <= count_d;
            expired_q <= expired_d;
        end
    end
    assign o_expired = expired_q;
endmodule : cbm_timer

// ---- hw/cbm_ctrl.sv ----
// Mode selection and boost fault supervision for the charger
`timescale 1ns/1ps
module cbm_ctrl #(
    parameter int unsigned BOOST_CYCLES = cbm_pkg::BOOST_TIMER_CYCLES,
    parameter int unsigned CRUDE_CYCLES = cbm_pkg::CRUDE_TIMER_CYCLES,
    parameter int unsigned OVERLOAD_LIMIT = cbm_pkg::OVERLOAD_CYCLES,
    parameter int unsigned PULSE_CYCLES = cbm_pkg::FAULT_PULSE_CYCLES,
    parameter int unsigned SOFT_CYCLES = cbm_pkg::SOFT_START_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_param_reset_wr,
    input wire logic i_operation_select_wr,
    input wire logic i_operation_select_val,
    input wire logic i_hiz_request_wr,
    input wire logic i_hiz_request_val,
    input wire logic i_timer_restart_wr,
    input wire logic i_fault_clear,
    input wire logic i_boost_request_pin,
    input wire logic i_bus_above_uvlo,
    input wire logic i_bus_overvoltage,
    input wire logic i_bus_overload,
    input wire logic i_battery_above_max,
    input wire logic i_battery_below_min,
    input wire logic i_battery_below_low,
    input wire logic i_charge_fault,
    input wire logic i_inductor_below_75ma,
    input wire logic i_output_node_droop,
    input wire logic i_low_side_over_1a,
    input wire logic i_status_pin_in,
    output logic o_operation_select_bit,
    output logic o_hiz_request_bit,
    output logic o_param_reset_bit,
    output logic o_timer_restart_bit,
    output logic o_param_defaults_load,
    output cbm_pkg::cbm_mode_t o_mode,
    output logic o_mode_32min,
    output logic o_boost_switching,
    output logic o_input_blocking_switch_linear,
    output logic o_low_side_switch_on,
    output logic [7:0] o_soft_start_level,
    output logic [cbm_pkg::FLT_W-1:0] o_fault_bits,
    output logic o_status_pin_out,
    output logic o_status_pin_oe
);
    import cbm_pkg::*;

    initial begin
        if (PULSE_CYCLES < 1 || OVERLOAD_LIMIT < 1 || SOFT_CYCLES < 1 || BOOST_CYCLES < 2 || CRUDE_CYCLES < 2) begin
            $error("cbm_ctrl counts too small");
        end
        if (PULSE_CYCLES > 32'h00000FFF || OVERLOAD_LIMIT > 32'h00100000 || BOOST_CYCLES > 32'h40000000
            || CRUDE_CYCLES > 32'h40000000) begin
            $error("cbm_ctrl counts too large");
        end
    end

    // ------------------------------------------------------------
    // Boost and crude timers
    // ------------------------------------------------------------
    logic boost_expired;
    logic crude_expired;
    logic boost_start;
    cbm_mode_t mode_q;
    cbm_mode_t mode_d;
    logic mode_32min_q;
    logic mode_32min_d;

    cbm_timer #(.WIDTH(30)) u_boost_timer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_run(mode_q == CBM_BOOST),
        .i_load(boost_start || i_timer_restart_wr),
        .i_count(30'(BOOST_CYCLES - 1)),
        .o_expired(boost_expired)
    );

    cbm_timer #(.WIDTH(30)) u_crude_timer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_run(mode_q == CBM_HIZ && i_battery_below_low && !mode_32min_q),
        .i_load(1'b0),
        .i_count(30'(CRUDE_CYCLES - 1)),
        .o_expired(crude_expired)
    );

    // ------------------------------------------------------------
    // Control bits and faults
    // ------------------------------------------------------------
    logic opsel_q;
    logic opsel_d;
    logic hiz_q;
    logic hiz_d;
    logic prst_q;
    logic prst_d;
    logic trst_q;
    logic trst_d;
    logic [FLT_W-1:0] flt_q;
    logic [FLT_W-1:0] flt_d;
    logic [FLT_W-1:0] new_flt;
    logic [19:0] ovl_q;
    logic [19:0] ovl_d;
    logic boosting;
    logic boost_req;
    logic ovl_fault;

    assign boosting = (mode_q == CBM_BOOST);
    assign boost_req = i_boost_request_pin || opsel_q;
    assign ovl_fault = boosting && i_bus_overload && (ovl_q >= 20'(OVERLOAD_LIMIT - 1));

    always_comb begin
        opsel_d = opsel_q;
        hiz_d = hiz_q;
        prst_d = 1'b0;
        trst_d = i_timer_restart_wr;
        ovl_d = (boosting && i_bus_overload) ? ovl_q + 20'h00001 : 20'h00000;
        new_flt = '0;
        new_flt[FLT_TIMER] = boosting && boost_expired;
        new_flt[FLT_BUS_OV] = boosting && i_bus_overvoltage;
        new_flt[FLT_OVERLOAD] = ovl_fault;
        new_flt[FLT_BAT_RANGE] = boosting && (i_battery_above_max || i_battery_below_min);
        new_flt[FLT_CHARGE] = (mode_q == CBM_CHARGE) && i_charge_fault;
        if (i_operation_select_wr) begin
            opsel_d = i_operation_select_val;
        end
        if (i_hiz_request_wr) begin
            hiz_d = i_hiz_request_val;
        end
        if (i_param_reset_wr) begin
            prst_d = 1'b1;
            opsel_d = RST_OPERATION_SELECT;
            hiz_d = RST_HIZ_REQUEST;
        end
        if (|new_flt[FLT_BAT_RANGE:FLT_BUS_OV]) begin
            opsel_d = 1'b0;
        end
        flt_d = (i_fault_clear ? '0 : flt_q) | new_flt;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            opsel_q <= RST_OPERATION_SELECT;
            hiz_q <= RST_HIZ_REQUEST;
            prst_q <= 1'b0;
            trst_q <= 1'b0;
            flt_q <= '0;
            ovl_q <= 20'h00000;
        end else begin
            opsel_q <= opsel_d;
            hiz_q <= hiz_d;
            prst_q <= prst_d;
            trst_q <= trst_d;
            flt_q <= flt_d;
            ovl_q <= ovl_d;
        end
    end

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    logic boost_block;
    assign boost_block = flt_q[FLT_OVERLOAD] || flt_q[FLT_TIMER];
    assign boost_start = (mode_q != CBM_BOOST) && (mode_d == CBM_BOOST);

    always_comb begin
        mode_32min_d = mode_32min_q;
        if (crude_expired) begin
            mode_32min_d = 1'b1;
        end
        if (i_param_reset_wr) begin
            mode_32min_d = RST_MODE_32MIN;
        end
        if (mode_32min_q && !i_bus_above_uvlo) begin
            mode_d = CBM_HIZ;
        end else if (hiz_q && !i_boost_request_pin) begin
            mode_d = CBM_HIZ;
        end else if (boost_req && !mode_32min_q) begin
            if (|new_flt || boost_block || i_bus_overvoltage || i_battery_above_max || i_battery_below_min) begin
                mode_d = CBM_CONFIG;
            end else begin
                mode_d = CBM_BOOST;
            end
        end else if (!i_bus_above_uvlo) begin
            mode_d = CBM_HIZ;
        end else if (i_charge_fault) begin
            mode_d = CBM_CONFIG;
        end else begin
            mode_d = CBM_CHARGE;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mode_q <= CBM_CHARGE;
            mode_32min_q <= RST_MODE_32MIN;
        end else begin
            mode_q <= mode_d;
            mode_32min_q <= mode_32min_d;
        end
    end

    // ------------------------------------------------------------
    // Boost power stage control
    // ------------------------------------------------------------
    logic pfm_idle_q;
    logic pfm_idle_d;
    logic [7:0] soft_q;
    logic [7:0] soft_d;
    logic [15:0] soft_div_q;
    logic [15:0] soft_div_d;
    logic sw_q;
    logic sw_d;
    logic ls_q;
    logic ls_d;
    logic lin_q;
    logic lin_d;

    always_comb begin
        pfm_idle_d = pfm_idle_q;
        soft_d = soft_q;
        soft_div_d = soft_div_q;
        if (!boosting || boost_start) begin
            pfm_idle_d = 1'b0;
            soft_d = 8'h00;
            soft_div_d = 16'h0000;
        end else begin
            if (i_inductor_below_75ma) begin
                pfm_idle_d = 1'b1;
            end else if (i_output_node_droop) begin
                pfm_idle_d = 1'b0;
            end
            if (soft_q != 8'hFF) begin
                if (soft_div_q >= 16'((SOFT_CYCLES + 254) / 255 - 1)) begin
                    soft_div_d = 16'h0000;
                    soft_d = soft_q + 8'h01;
                end else begin
                    soft_div_d = soft_div_q + 16'h0001;
                end
            end
        end
        sw_d = (mode_d == CBM_BOOST) && boosting && !pfm_idle_d;
        ls_d = sw_d && !i_low_side_over_1a;
        lin_d = boosting && i_bus_overload;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pfm_idle_q <= 1'b0;
            soft_q <= 8'h00;
            soft_div_q <= 16'h0000;
            sw_q <= 1'b0;
            ls_q <= 1'b0;
            lin_q <= 1'b0;
        end else begin
            pfm_idle_q <= pfm_idle_d;
            soft_q <= soft_d;
            soft_div_q <= soft_div_d;
            sw_q <= sw_d;
            ls_q <= ls_d;
            lin_q <= lin_d;
        end
    end

    // ------------------------------------------------------------
    // Status pin fault pulse
    // ------------------------------------------------------------
    logic [11:0] pulse_q;
    logic [11:0] pulse_d;
    logic [FLT_W-1:0] cond_q;
    logic oe_q;
    logic oe_d;

    always_comb begin
        pulse_d = pulse_q;
        if ((new_flt & ~cond_q) != '0) begin
            pulse_d = 12'(PULSE_CYCLES);
        end else if (pulse_q != 12'h000) begin
            pulse_d = pulse_q - 12'h001;
        end
        oe_d = (pulse_d != 12'h000);
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pulse_q <= 12'h000;
            cond_q <= '0;
            oe_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            cond_q <= new_flt;
            oe_q <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_operation_select_bit = opsel_q;
    assign o_hiz_request_bit = hiz_q;
    assign o_param_reset_bit = prst_q;
    assign o_timer_restart_bit = trst_q;
    assign o_param_defaults_load = prst_q;
    assign o_mode = mode_q;
    assign o_mode_32min = mode_32min_q;
    assign o_boost_switching = sw_q;
    assign o_input_blocking_switch_linear = lin_q;
    assign o_low_side_switch_on = ls_q;
    assign o_soft_start_level = soft_q;
    assign o_fault_bits = flt_q;
    assign o_status_pin_out = 1'b0;
    assign o_status_pin_oe = oe_q;
endmodule : cbm_ctrl

// ---- bench/cbm_ctrl_monitor.sv ----
// Assertion checker for the boost mode control ports
`timescale 1ns/1ps
module cbm_ctrl_monitor #(
    parameter int unsigned OVERLOAD_LIMIT = 20
) (
    input wire logic i_clock, i_reset, i_param_reset_wr, i_fault_clear, i_boost_request_pin,
    input wire logic i_bus_above_uvlo, i_bus_overvoltage, i_bus_overload,
    input wire logic i_inductor_below_75ma, i_output_node_droop, i_low_side_over_1a,
    input wire logic o_param_reset_bit, o_hiz_request_bit, o_operation_select_bit, o_mode_32min,
    input wire logic o_boost_switching, o_input_blocking_switch_linear, o_low_side_switch_on,
    input wire logic o_status_pin_oe,
    input wire cbm_pkg::cbm_mode_t o_mode,
    input wire logic [cbm_pkg::FLT_W-1:0] o_fault_bits
);
    import cbm_pkg::*;
    int unsigned ol_q;
    logic boost;
    assign boost = o_mode == CBM_BOOST;
    // Cycles of overload seen since it began in boost
    always_ff @(posedge i_clock) begin
        ol_q <= (i_reset || !i_bus_overload || (!boost && ol_q == 0)) ? 0 : ol_q + 1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    param_clear_a: assert property ($fell(i_param_reset_wr) |-> o_param_reset_bit ##1 !o_param_reset_bit)
        else $error("param reset bit not self cleared");
    hiz_mode_a: assert property (o_hiz_request_bit && !i_boost_request_pin && $past(o_hiz_request_bit)
        && !$past(i_boost_request_pin) |-> o_mode == CBM_HIZ) else $error("hiz request ignored");
    lockout_hiz_a: assert property (o_mode_32min && !i_bus_above_uvlo && $past(o_mode_32min)
        && !$past(i_bus_above_uvlo) |-> o_mode == CBM_HIZ) else $error("lockout not hiz");
    ovp_stop_a: assert property (boost && i_bus_overvoltage |=> o_mode == CBM_CONFIG
        && !o_operation_select_bit && o_fault_bits[FLT_BUS_OV]) else $error("overvoltage not handled");
    pulse_len_a: assert property ($rose(o_status_pin_oe) |-> o_status_pin_oe [*4] ##1 !o_status_pin_oe)
        else $error("status pulse length wrong");
    fault_hold_a: assert property (!i_fault_clear
        |=> (o_fault_bits & $past(o_fault_bits)) == $past(o_fault_bits)) else $error("fault bit lost");
    ol_refuse_a: assert property (o_fault_bits[FLT_OVERLOAD] && $past(o_fault_bits[FLT_OVERLOAD])
        |-> !boost) else $error("boost while overload fault");
    ol_time_a: assert property (ol_q == OVERLOAD_LIMIT + 3 |-> o_fault_bits[FLT_OVERLOAD])
        else $error("overload fault missing");
    ol_linear_a: assert property (boost && i_bus_overload && $past(boost && i_bus_overload)
        |-> o_input_blocking_switch_linear) else $error("no current limit");
    pfm_stop_a: assert property (boost && $past(boost) && $past(i_inductor_below_75ma)
        && !$past(i_output_node_droop) |-> !o_boost_switching) else $error("no pulse skip");
    limit_a: assert property (boost && $past(boost && i_low_side_over_1a) |-> !o_low_side_switch_on)
        else $error("no current limit on switch");
endmodule : cbm_ctrl_monitor

bind cbm_ctrl cbm_ctrl_monitor #(.OVERLOAD_LIMIT(OVERLOAD_LIMIT)) u_mon (.i_clock, .i_reset, .i_param_reset_wr,
    .i_fault_clear, .i_boost_request_pin, .i_bus_above_uvlo, .i_bus_overvoltage, .i_bus_overload,
    .i_inductor_below_75ma, .i_output_node_droop, .i_low_side_over_1a, .o_param_reset_bit, .o_hiz_request_bit,
    .o_operation_select_bit, .o_mode_32min, .o_boost_switching, .o_input_blocking_switch_linear,
    .o_low_side_switch_on, .o_status_pin_oe, .o_mode, .o_fault_bits);

// ---- bench/cbm_host_model.sv ----
// Host processor model that writes the control bits
`timescale 1ns/1ps
module cbm_host_model (
    input wire logic i_clock,
    input wire logic i_keep,
    output logic [4:0] o_wr,
    output logic o_val
);
    logic [4:0] w = 5'h00;
    logic kp = 1'h0;
    int unsigned gap = 0;
    initial o_val = 1'h0;
    assign o_wr = w | {1'h0, kp, 3'h0};
    // Keep-alive restart every 100 cycles, well inside the timer
    always @(posedge i_clock) begin
        #5;
        kp = i_keep && (gap % 100 == 99);
        gap = i_keep ? gap + 1 : 0;
    end
    // One-cycle write strobe; parameter reset is issued like any other write, in any mode
    task automatic put(input int k, input logic v);
        @(posedge i_clock);
        #5;
        w[k] = 1'h1;
        o_val = v;
        @(posedge i_clock);
        #5;
        w = 5'h00;
    endtask : put
endmodule : cbm_host_model

// ---- bench/cbm_ctrl_tb_top.sv ----
// Self-checking testbench for the boost mode control block
`timescale 1ns/1ps
module cbm_ctrl_tb_top;
    import cbm_pkg::*;
    localparam int BT = 200;
    localparam int CT = 200;
    localparam int OL = 20;
    localparam int P = 10, U = 9, OV = 8, OLD = 7, BMX = 6, BMN = 5, BL = 4, CF = 3, IND = 2, DR = 1, LS = 0;
    logic i_clock, i_reset, i_keep, hval;
    logic [4:0] hwr;
    logic [10:0] cmp;
    logic o_operation_select_bit, o_hiz_request_bit, o_param_reset_bit, o_timer_restart_bit;
    logic o_param_defaults_load, o_mode_32min, o_boost_switching, o_input_blocking_switch_linear;
    logic o_low_side_switch_on, o_status_pin_out, o_status_pin_oe;
    logic [7:0] o_soft_start_level;
    logic [FLT_W-1:0] o_fault_bits;
    cbm_mode_t o_mode;
    int errors, cmp_count;
    cbm_ctrl #(.BOOST_CYCLES(BT), .CRUDE_CYCLES(CT), .OVERLOAD_LIMIT(OL), .PULSE_CYCLES(4), .SOFT_CYCLES(300)) DUT (
        .i_clock, .i_reset, .i_param_reset_wr(hwr[0]), .i_operation_select_wr(hwr[1]), .i_operation_select_val(hval),
        .i_hiz_request_wr(hwr[2]), .i_hiz_request_val(hval), .i_timer_restart_wr(hwr[3]), .i_fault_clear(hwr[4]),
        .i_boost_request_pin(cmp[P]), .i_bus_above_uvlo(cmp[U]), .i_bus_overvoltage(cmp[OV]),
        .i_bus_overload(cmp[OLD]), .i_battery_above_max(cmp[BMX]), .i_battery_below_min(cmp[BMN]),
        .i_battery_below_low(cmp[BL]), .i_charge_fault(cmp[CF]), .i_inductor_below_75ma(cmp[IND]),
        .i_output_node_droop(cmp[DR]), .i_low_side_over_1a(cmp[LS]), .i_status_pin_in(!o_status_pin_oe),
        .o_operation_select_bit, .o_hiz_request_bit, .o_param_reset_bit, .o_timer_restart_bit, .o_param_defaults_load,
        .o_mode, .o_mode_32min, .o_boost_switching, .o_input_blocking_switch_linear, .o_low_side_switch_on,
        .o_soft_start_level, .o_fault_bits, .o_status_pin_out, .o_status_pin_oe);
    cbm_host_model host (.i_clock, .i_keep, .o_wr(hwr), .o_val(hval));
    initial begin
        i_clock = 1'h0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #5;
    endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic setc(input int b, input logic v);
        cmp[b] = v;
        cyc(3);
    endtask : setc
    // Counts status pin low cycles over a window
    task automatic ohi(input int n, output int h);
        h = 0;
        repeat (n) begin
            cyc(1);
            h += o_status_pin_oe;
        end
    endtask : ohi
    task automatic t_modes();
        chk(o_mode, CBM_CHARGE, "charge");
        setc(CF, 1);
        chk(o_mode, CBM_CONFIG, "configure");
        setc(U, 0);
        chk(o_mode, CBM_HIZ, "uvlo hiz");
        setc(CF, 0);
        host.put(2, 1);
        host.put(0, 0);
        chk(o_param_reset_bit, 1, "param bit");
        chk(o_param_defaults_load, 1, "defaults");
        chk(o_hiz_request_bit, 0, "hiz default");
        cyc(1);
        chk(o_param_reset_bit, 0, "param clear");
        setc(U, 1);
        host.put(2, 1);
        cyc(2);
        chk(o_mode, CBM_HIZ, "hiz");
        setc(P, 1);
        chk(o_mode, CBM_BOOST, "pin boost");
        setc(P, 0);
        host.put(2, 0);
        $display("modes done");
    endtask : t_modes
    task automatic t_boost();
        int h;
        logic [7:0] lv;
        host.put(1, 1);
        cyc(1);
        chk(o_mode, CBM_BOOST, "boost");
        lv = o_soft_start_level;
        cyc(50);
        chk(o_soft_start_level > lv, 1, "ramp");
        setc(IND, 1);
        chk(o_boost_switching, 0, "skip");
        cmp[IND] = 0;
        setc(DR, 1);
        chk(o_boost_switching, 1, "resume");
        cmp[DR] = 0;
        setc(LS, 1);
        chk(o_low_side_switch_on, 0, "limit");
        cmp[LS] = 0;
        i_keep = 1;
        cyc(450);
        i_keep = 0;
        chk(o_mode, CBM_BOOST, "kept");
        host.put(3, 0);
        chk(o_timer_restart_bit, 1, "restart bit");
        ohi(BT - 20, h);
        chk(o_timer_restart_bit, 0, "restart clear");
        chk(o_mode, CBM_BOOST, "timer early");
        ohi(60, h);
        chk(o_mode, CBM_CONFIG, "expired");
        chk(o_fault_bits[FLT_TIMER], 1, "timer bit");
        chk(h, 4, "timer pulse");
        host.put(4, 0);
        host.put(1, 1);
        cyc(2);
        chk(o_fault_bits, 0, "cleared");
        chk(o_mode, CBM_BOOST, "reboost");
        $display("boost done");
    endtask : t_boost
    task automatic t_faults();
        int h;
        int g;
        int src[3] = '{OV, BMX, BMN};
        int fb[3] = '{FLT_BUS_OV, FLT_BAT_RANGE, FLT_BAT_RANGE};
        for (int i = 0; i < 3; i++) begin
            cmp[src[i]] = 1;
            ohi(1, h);
            chk(o_mode, CBM_CONFIG, "fault mode");
            chk(o_operation_select_bit, 0, "select off");
            chk(o_fault_bits[fb[i]], 1, "fault bit");
            chk(o_status_pin_out, 0, "pin low");
            ohi(20, g);
            chk(h + g, 4, "one pulse");
            cmp[src[i]] = 0;
            host.put(1, 1);
            cyc(2);
            chk(o_mode, CBM_BOOST, "restart");
            host.put(4, 0);
        end
        $display("faults done");
    endtask : t_faults
    task automatic t_overload();
        cmp[OLD] = 1;
        cyc(OL - 5);
        chk(o_mode, CBM_BOOST, "limit first");
        chk(o_input_blocking_switch_linear, 1, "linear");
        cyc(10);
        chk(o_fault_bits[FLT_OVERLOAD], 1, "overload");
        chk(o_operation_select_bit, 0, "select off");
        cmp[OLD] = 0;
        host.put(1, 1);
        cyc(2);
        chk(o_mode, CBM_CONFIG, "refused");
        host.put(4, 0);
        host.put(1, 1);
        cyc(2);
        chk(o_mode, CBM_BOOST, "after clear");
        host.put(1, 0);
        $display("overload done");
    endtask : t_overload
    task automatic t_crude();
        host.put(2, 1);
        cmp[BL] = 1;
        cyc(CT - 20);
        chk(o_mode_32min, 0, "early");
        cyc(40);
        chk(o_mode_32min, 1, "32 min");
        host.put(2, 0);
        cmp[P] = 1;
        setc(U, 0);
        chk(o_mode, CBM_HIZ, "lockout");
        $display("crude done");
    endtask : t_crude
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge i_clock);
        errors++;
        end_of_test();
    end
    initial begin
        i_reset = 1;
        i_keep = 0;
        cmp = 11'h200;
        errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge i_clock);
        #5 i_reset = 0;
        t_modes();
        t_boost();
        t_faults();
        t_overload();
        t_crude();
        end_of_test();
    end
endmodule : cbm_ctrl_tb_top
